//--- rtl/slc_leveling_logic.sv
// leveling command logic: command state bits, drive selection, ahb-lite slave
// assumes command, coarse sensor and preset pins are asynchronous; tidal words
// and the ahb-lite bus run on core_clk
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
module slc_leveling_logic
   import slc_pkg::*;
(
   input wire logic core_clk, // 200 MHz block clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic [NUM_CMD-1:0] cmdLine, // command pulse pins
   input wire logic [NUM_HORIZ-1:0] coarseLevelIn, // coarse sensor pins, 1 = minus
   input wire logic presetIn, // power-up preset pulse pin
   input wire slc_drive_t [AXES-1:0] tidalErr, // tidal error words, core_clk
   input wire slc_ahb_in_s ahbIn, // ahb-lite requests
   output slc_ahb_out_s ahbOut, // ahb-lite answers
   output logic [AXES-1:0] motorPower, // motor drive power per axis
   output logic coarseSensorPower, // horizontal coarse sensor power
   output logic filterBypass, // feedback filter bypass, all axes
   output logic [AXES-1:0] pulsePlus, // plus drive pulses
   output logic [AXES-1:0] pulseMinus // minus drive pulses
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [NUM_LINES-1:0] rawLines;
   logic [NUM_LINES-1:0] lineLevel;
   logic [NUM_LINES-1:0] lineRise;

   // every pin, command or not, goes through the same chain
   assign rawLines = {presetIn, coarseLevelIn, cmdLine};

   for (genvar i = 0; i < NUM_LINES; i++) begin : g_sync
      slc_line_sync u_sync (
         .core_clk(core_clk),
         .reset_n(reset_n),
         .ce(ce),
         .lineIn(rawLines[i]),
         .level(lineLevel[i]),
         .rise(lineRise[i])
      );
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CMD-1:0] cmdBits;
      logic bypass;
      logic sensorPower;
      logic [AMP_W-1:0] ampLow;
      logic [AMP_W-1:0] ampHigh;
      logic [AMP_W-1:0] ampCoarse;
      logic [NUM_CMD-1:0] swFire;
      logic wrPend;
      logic [ADDR_W-1:0] wrAddr;
      slc_drive_t [AXES-1:0] drive;
      slc_ahb_out_s bus;
   } slc_top_state_s;

   localparam slc_top_state_s TOP_RESET = '{
      cmdBits: PRESET_CMD,
      bypass: 1'b0,
      sensorPower: 1'b0,
      ampLow: AMP_LOW_RST,
      ampHigh: AMP_HIGH_RST,
      ampCoarse: AMP_COARSE_RST,
      swFire: '0,
      wrPend: 1'b0,
      wrAddr: '0,
      drive: '0,
      bus: BUS_OUT_RST
   };

   slc_top_state_s st_reg;
   slc_top_state_s st_next;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   logic autoMode;
   logic coarseOn;
   logic fineOn;
   logic cmdOn;
   logic bypassCond;
   logic [AMP_W-1:0] cmdMag;
   logic [NUM_CMD-1:0] fire;

   // command mode opens the automatic switch, killing both submodes
   assign autoMode = !st_reg.cmdBits[CMD_MODE];
   assign cmdOn = st_reg.cmdBits[CMD_MODE];
   assign coarseOn = autoMode && st_reg.cmdBits[CMD_COARSE];
   assign fineOn = autoMode && !st_reg.cmdBits[CMD_COARSE];
   assign bypassCond = coarseOn || (cmdOn && st_reg.cmdBits[CMD_SPEED]);
   assign cmdMag = st_reg.cmdBits[CMD_SPEED] ? st_reg.ampHigh : st_reg.ampLow;

   // a pin edge and a software write in one cycle count as one pulse
   assign fire = lineRise[NUM_CMD-1:0] | st_reg.swFire;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      slc_drive_t cmdDrv;
      slc_drive_t coarsePos;
      slc_drive_t coarseNeg;
      logic accept;
      logic [31:0] rd;
      cmdDrv = '0;
      coarsePos = '0;
      coarseNeg = '0;
      accept = 1'b0;
      rd = '0;
      st_next = st_reg;
      st_next.swFire = '0;

      // bistable bits: every pulse flips its own bit
      st_next.cmdBits = st_reg.cmdBits ^ fire;
      // preset wins over any pulse arriving with it
      if (lineRise[LINE_PRESET]) begin
         st_next.cmdBits = PRESET_CMD;
      end

      // switch outputs are registered so the ports come from flops
      st_next.bypass = bypassCond;
      st_next.sensorPower = coarseOn;

      // drive words for each submode
      cmdDrv = slc_drive_t'({1'b0, cmdMag});
      if (st_reg.cmdBits[CMD_DIR]) begin
         cmdDrv = slc_drive_t'(-cmdDrv);
      end
      coarsePos = slc_drive_t'({1'b0, st_reg.ampCoarse});
      coarseNeg = slc_drive_t'(-coarsePos);

      // only the drive circuit of the active mode feeds the generator
      for (int a = 0; a < AXES; a++) begin
         st_next.drive[a] = '0;
         if (st_reg.cmdBits[CMD_MOTOR_X + a]) begin
            if (fineOn) begin
               st_next.drive[a] = tidalErr[a];
            end else if (coarseOn && a < NUM_HORIZ) begin
               st_next.drive[a] = lineLevel[LINE_COARSE_X + a] ? coarseNeg : coarsePos;
            end else if (cmdOn) begin
               st_next.drive[a] = cmdDrv;
            end
         end
      end

      // ahb-lite address phase: zero wait, answer is always okay
      accept = ahbIn.hsel && ahbIn.hready && ahbIn.htrans[HTRANS_ACT_BIT];
      st_next.wrPend = accept && ahbIn.hwrite;
      st_next.wrAddr = ahbIn.haddr[ADDR_W-1:0];
      st_next.bus.hreadyout = 1'b1;
      st_next.bus.hresp = 1'b0;

      // read data is captured in the address phase
      case (ahbIn.haddr[ADDR_W-1:0])
         ADDR_STATUS: begin
            rd[STAT_CMD_LSB +: NUM_CMD] = st_reg.cmdBits;
            rd[STAT_BYPASS_BIT] = st_reg.bypass;
            rd[STAT_SENSOR_BIT] = st_reg.sensorPower;
         end
         ADDR_AMP: begin
            rd[AMP_LOW_LSB +: AMP_W] = st_reg.ampLow;
            rd[AMP_HIGH_LSB +: AMP_W] = st_reg.ampHigh;
            rd[AMP_COARSE_LSB +: AMP_W] = st_reg.ampCoarse;
         end
         default: begin
            rd = '0;
         end
      endcase
      if (accept && !ahbIn.hwrite) begin
         st_next.bus.hrdata = rd;
      end

      // write data phase; the command register fires pulses a clock later
      if (st_reg.wrPend) begin
         case (st_reg.wrAddr)
            ADDR_CMD: begin
               st_next.swFire = ahbIn.hwdata[NUM_CMD-1:0];
            end
            ADDR_AMP: begin
               st_next.ampLow = ahbIn.hwdata[AMP_LOW_LSB +: AMP_W];
               st_next.ampHigh = ahbIn.hwdata[AMP_HIGH_LSB +: AMP_W];
               st_next.ampCoarse = ahbIn.hwdata[AMP_COARSE_LSB +: AMP_W];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // clock enable low holds everything, bus answer included
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg <= TOP_RESET;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // drive pulse generators
   // ----------------------------------------------------------------
   for (genvar a = 0; a < AXES; a++) begin : g_pwm
      slc_pulse_gen #(
         .DW(DRV_W)
      ) u_pwm (
         .core_clk(core_clk),
         .reset_n(reset_n),
         .ce(ce),
         .driveIn(st_reg.drive[a]),
         .pulsePlus(pulsePlus[a]),
         .pulseMinus(pulseMinus[a])
      );
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign motorPower = st_reg.cmdBits[CMD_MOTOR_X +: AXES];
   assign coarseSensorPower = st_reg.sensorPower;
   assign filterBypass = st_reg.bypass;
   assign ahbOut = st_reg.bus;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // a lone x motor pulse flips x motor power
   property p_motor_toggle;
      ce && lineRise[CMD_MOTOR_X] && !st_reg.swFire[CMD_MOTOR_X]
         && !lineRise[LINE_PRESET] |=> motorPower[0] != $past(motorPower[0]);
   endproperty
   a_motor_toggle: assert property (p_motor_toggle) else $error("motor bit no toggle");

   // a pin pulse toggles the mode exactly once
   property p_mode_toggle;
      ce && lineRise[CMD_MODE] && !st_reg.swFire[CMD_MODE] && !lineRise[LINE_PRESET]
         |=> st_reg.cmdBits[CMD_MODE] != $past(st_reg.cmdBits[CMD_MODE]);
   endproperty
   a_mode_toggle: assert property (p_mode_toggle) else $error("mode bit no toggle");

   property p_preset;
      ce && lineRise[LINE_PRESET] |=> st_reg.cmdBits == PRESET_CMD && motorPower == '0;
   endproperty
   a_preset: assert property (p_preset) else $error("preset not applied");

   property p_bypass;
      ce |=> filterBypass == $past(bypassCond);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass wrong");

   property p_cmd_no_sensor;
      ce && cmdOn |=> !coarseSensorPower;
   endproperty
   a_cmd_no_sensor: assert property (p_cmd_no_sensor) else $error("sensor on in command");

   property p_coarse_sensor;
      ce && coarseOn |=> coarseSensorPower;
   endproperty
   a_coarse_sensor: assert property (p_coarse_sensor) else $error("sensor off in coarse");

   property p_vertical_no_coarse;
      ce && coarseOn |=> st_reg.drive[AXES-1] == '0;
   endproperty
   a_vertical_no_coarse: assert property (p_vertical_no_coarse) else $error("z coarse drive");

   property p_fine_tidal;
      ce && fineOn && motorPower[0] |=> st_reg.drive[0] == $past(tidalErr[0]);
   endproperty
   a_fine_tidal: assert property (p_fine_tidal) else $error("fine drive not tidal");

   property p_cmd_minus;
      ce && cmdOn && motorPower[0] && st_reg.cmdBits[CMD_DIR]
         |=> st_reg.drive[0][DRV_W-1] || $past(cmdMag) == '0;
   endproperty
   a_cmd_minus: assert property (p_cmd_minus) else $error("minus drive not negative");

   property p_cmd_speed;
      ce && cmdOn && motorPower[0] && !st_reg.cmdBits[CMD_DIR]
         |=> st_reg.drive[0] == slc_drive_t'({1'b0, $past(cmdMag)});
   endproperty
   a_cmd_speed: assert property (p_cmd_speed) else $error("command amplitude wrong");

   property p_coarse_path;
      ce && coarseOn && motorPower[1]
         |=> st_reg.drive[1] == slc_drive_t'({1'b0, $past(st_reg.ampCoarse)})
            || st_reg.drive[1] == slc_drive_t'(-slc_drive_t'({1'b0, $past(st_reg.ampCoarse)}));
   endproperty
   a_coarse_path: assert property (p_coarse_path) else $error("coarse path not used");

   // a second coarse pin pulse always clears the coarse bit, in either mode
   property p_coarse_return;
      ce && lineRise[CMD_COARSE] && !st_reg.swFire[CMD_COARSE] && !lineRise[LINE_PRESET]
         && st_reg.cmdBits[CMD_COARSE] |=> !st_reg.cmdBits[CMD_COARSE];
   endproperty
   a_coarse_return: assert property (p_coarse_return) else $error("coarse not cleared");

   // a status read hands back the state bits standing in its address phase
   sequence s_status_read;
      ce && ahbIn.hsel && ahbIn.hready && ahbIn.htrans[HTRANS_ACT_BIT] && !ahbIn.hwrite
         && ahbIn.haddr[ADDR_W-1:0] == ADDR_STATUS;
   endsequence
   property p_status_read;
      s_status_read |=> ahbOut.hrdata[STAT_CMD_LSB +: NUM_CMD] == $past(st_reg.cmdBits);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   // software direction pulse: address, then data, then one flip a clock later
   sequence s_dir_write;
      ce && ahbIn.hsel && ahbIn.hready && ahbIn.htrans[HTRANS_ACT_BIT] && ahbIn.hwrite
         && ahbIn.haddr[ADDR_W-1:0] == ADDR_CMD
         ##1 ce && ahbIn.hwdata[CMD_DIR] ##1 ce && !lineRise[LINE_PRESET];
   endsequence
   property p_dir_write;
      s_dir_write |=> st_reg.cmdBits[CMD_DIR] != $past(st_reg.cmdBits[CMD_DIR]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write no toggle");

endmodule

//--- rtl/slc_line_sync.sv
// one asynchronous pin: three-flop synchroniser, agreed level and rise pulse
// assumes the pin is slow against core_clk; a pulse must last two clocks
`timescale 1ns/100ps
module slc_line_sync
   import slc_pkg::*;
(
   input wire logic core_clk, // block clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes state when low
   input wire logic lineIn, // raw pin
   output logic level, // agreed level
   output logic rise // one-clock pulse on an agreed rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } slc_sync_state_s;

   slc_sync_state_s st_reg;
   slc_sync_state_s st_next;

   // ----------------------------------------------------------------
   // chain and agreement
   // ----------------------------------------------------------------
   // s1 feeds only s2; the level moves only when s2 and s3 agree
   always_comb begin
      st_next = st_reg;
      st_next.s1 = lineIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.rise = 1'b0;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.level = st_reg.s3;
         st_next.rise = st_reg.s3 && !st_reg.level;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;
   assign rise = st_reg.rise;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_agree_high;
      ce && st_reg.s2 && st_reg.s3 && !st_reg.level;
   endsequence
   property p_single_rise;
      s_agree_high |=> rise && level ##1 (!$past(ce) || !rise);
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("rise not single");
endmodule

//--- rtl/slc_pkg.sv
// shared constants and carriers for the seismometer leveling command logic
// assumes a single core_clk domain; pins are synchronised inside the block
package slc_pkg;

   // ----------------------------------------------------------------
   // command line and pin indices
   // ----------------------------------------------------------------
   localparam int NUM_CMD = 7;
   localparam int AXES = 3;
   localparam int NUM_HORIZ = 2;
   localparam int CMD_MOTOR_X = 0;
   localparam int CMD_MODE = 3;
   localparam int CMD_COARSE = 4;
   localparam int CMD_DIR = 5;
   localparam int CMD_SPEED = 6;
   localparam int LINE_COARSE_X = 7;
   localparam int LINE_PRESET = 9;
   localparam int NUM_LINES = 10;

   // preset: motors off, automatic, coarse off, plus, low speed
   localparam logic [NUM_CMD-1:0] PRESET_CMD = 7'h00;

   // ----------------------------------------------------------------
   // drive words and amplitudes
   // ----------------------------------------------------------------
   localparam int DRV_W = 8;
   localparam int AMP_W = DRV_W - 1;
   localparam logic [AMP_W-1:0] AMP_LOW_RST = 7'h10;
   localparam logic [AMP_W-1:0] AMP_HIGH_RST = 7'h40;
   localparam logic [AMP_W-1:0] AMP_COARSE_RST = 7'h60;
   typedef logic signed [DRV_W-1:0] slc_drive_t;

   // ----------------------------------------------------------------
   // register map and field layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_AMP = 8'h08;
   localparam int AMP_LOW_LSB = 0;
   localparam int AMP_HIGH_LSB = 8;
   localparam int AMP_COARSE_LSB = 16;
   localparam int STAT_CMD_LSB = 0;
   localparam int STAT_BYPASS_BIT = 7;
   localparam int STAT_SENSOR_BIT = 8;
   localparam int HTRANS_ACT_BIT = 1;

   // ----------------------------------------------------------------
   // ahb-lite carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } slc_ahb_in_s;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } slc_ahb_out_s;

   localparam slc_ahb_out_s BUS_OUT_RST = '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0};

endpackage

//--- rtl/slc_pulse_gen.sv
// bidirectional drive pulse generator for one axis
// assumes the drive word is registered in the same clock domain
`timescale 1ns/100ps
module slc_pulse_gen
   import slc_pkg::*;
#(
   parameter int DW = DRV_W // drive word width; period is 2**(DW-1)
) (
   input wire logic core_clk, // block clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic ce, // clock enable
   input wire logic signed [DW-1:0] driveIn, // signed drive word
   output logic pulsePlus, // plus drive pulse
   output logic pulseMinus // minus drive pulse
);
   typedef struct packed {
      logic [DW-2:0] cnt;
      logic [DW-1:0] mag;
      logic neg;
      logic outPlus;
      logic outMinus;
   } slc_pwm_state_s;

   slc_pwm_state_s st_reg;
   slc_pwm_state_s st_next;

   // ----------------------------------------------------------------
   // width tracks magnitude, side tracks sign
   // ----------------------------------------------------------------
   // the word is latched once per period so a width never splits
   always_comb begin
      logic onTime;
      onTime = 1'b0;
      st_next = st_reg;
      st_next.cnt = st_reg.cnt + 1'b1;
      if (st_reg.cnt == '0) begin
         st_next.neg = driveIn[DW-1];
         st_next.mag = driveIn[DW-1] ? DW'(-driveIn) : DW'(driveIn);
      end
      onTime = {1'b0, st_reg.cnt} < st_reg.mag;
      st_next.outPlus = onTime && !st_reg.neg;
      st_next.outMinus = onTime && st_reg.neg;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign pulsePlus = st_reg.outPlus;
   assign pulseMinus = st_reg.outMinus;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_latch_zero;
      ce && st_reg.cnt == '0 && driveIn == '0 ##1 ce;
   endsequence
   property p_zero_drive;
      s_latch_zero |=> !pulsePlus && !pulseMinus;
   endproperty
   a_zero_drive: assert property (p_zero_drive) else $error("pulse on zero drive");
   property p_one_side;
      !(pulsePlus && pulseMinus);
   endproperty
   a_one_side: assert property (p_one_side) else $error("both polarities");
endmodule

//--- verification/slc_cmd_source.sv
// behavioural command source: single pulses on the command and preset pins
// assumes the bench calls pulse() right after a rising edge of core_clk
`timescale 1ns/100ps
module slc_cmd_source
   import slc_pkg::*;
(
   input wire logic core_clk, // block clock
   output logic [NUM_CMD-1:0] cmdLine, // command pulse pins
   output logic presetIn // power-up preset pin
);
   // ----------------------------------------------------------------
   // pulse issue
   // ----------------------------------------------------------------
   // pins idle low between commands
   initial begin
      cmdLine = '0;
      presetIn = 1'b0;
   end

   // one line at a time, a command is one pulse
   // three clocks high and low, clear of the synchroniser minimum
   task automatic pulse(input int n);
      @(posedge core_clk);
      if (n == NUM_CMD) presetIn <= 1'b1;
      else cmdLine[n] <= 1'b1;
      repeat (3) @(posedge core_clk);
      cmdLine <= '0;
      presetIn <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
endmodule

//--- verification/slc_leveling_logic_tb.sv
// self-checking bench for the leveling command logic with a reference model
// assumes zero-wait ahb-lite answers and a 128-clock pulse period
`timescale 1ns/100ps
module slc_leveling_logic_tb;
   import slc_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n;
   logic ce;
   logic [NUM_CMD-1:0] cmdLine;
   logic [NUM_HORIZ-1:0] coarseLevelIn;
   logic presetIn;
   slc_drive_t [AXES-1:0] tidalErr;
   slc_ahb_in_s req;
   slc_ahb_in_s ahbIn;
   slc_ahb_out_s ahbOut;
   logic [AXES-1:0] motorPower;
   logic coarseSensorPower;
   logic filterBypass;
   logic [AXES-1:0] pulsePlus;
   logic [AXES-1:0] pulseMinus;
   logic [6:0] st = 7'h00;
   int ampL = 16;
   int ampH = 64;
   int ampC = 96;
   int err_total = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'hf3415b7c;
   logic [31:0] rd;
   logic [31:0] wv;

   // ----------------------------------------------------------------
   // clock, bus wiring, instances
   // ----------------------------------------------------------------
   always #2.5 core_clk = ~core_clk;
   // the one slave's hreadyout is the bus hready
   always_comb begin
      ahbIn = req;
      ahbIn.hready = ahbOut.hreadyout;
   end
   slc_cmd_source i_src (.core_clk(core_clk), .cmdLine(cmdLine), .presetIn(presetIn));
   slc_leveling_logic i_dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce),
      .cmdLine(cmdLine), .coarseLevelIn(coarseLevelIn), .presetIn(presetIn),
      .tidalErr(tidalErr), .ahbIn(ahbIn), .ahbOut(ahbOut), .motorPower(motorPower),
      .coarseSensorPower(coarseSensorPower), .filterBypass(filterBypass),
      .pulsePlus(pulsePlus), .pulseMinus(pulseMinus));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // reference drive word of one axis, from the model state
   function automatic int drv(input int a);
      int v;
      if (!st[a]) return 0;
      if (st[CMD_MODE]) begin
         v = st[CMD_SPEED] ? ampH : ampL;
         return st[CMD_DIR] ? -v : v;
      end
      if (st[CMD_COARSE]) return (a == 2) ? 0 : (coarseLevelIn[a] ? -ampC : ampC);
      return int'($signed(tidalErr[a]));
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one single transfer; the master waits for hready, never a fixed count
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
         output logic [31:0] r);
      req.hsel <= 1'b1;
      req.haddr <= a;
      req.htrans <= 2'b10;
      req.hwrite <= w;
      req.hsize <= 3'b010;
      do @(posedge core_clk); while (ahbIn.hready !== 1'b1);
      req.htrans <= 2'b00;
      req.hwdata <= wd;
      do @(posedge core_clk); while (ahbIn.hready !== 1'b1);
      // hsel stays up between transfers, the idle htrans marks the gap
      r = ahbOut.hrdata;
   endtask

   task automatic cmd_pin(input int n);
      i_src.pulse(n);
      st[n] = ~st[n];
   endtask

   task automatic cmd_reg(input logic [6:0] m);
      bus(ADDR_CMD, 1'b1, {25'h0, m}, rd);
      st ^= m;
   endtask

   // fresh inputs, let two pulse periods pass, then compare every output
   task automatic check_all();
      int np[AXES];
      int nm[AXES];
      int d;
      logic s;
      logic b;
      tidalErr <= (AXES*DRV_W)'(rnd());
      repeat (300) @(posedge core_clk);
      np = '{0, 0, 0};
      nm = '{0, 0, 0};
      repeat (128) begin
         @(posedge core_clk);
         for (int a = 0; a < AXES; a++) begin
            np[a] += int'(pulsePlus[a]);
            nm[a] += int'(pulseMinus[a]);
         end
      end
      s = !st[CMD_MODE] && st[CMD_COARSE];
      b = s || (st[CMD_MODE] && st[CMD_SPEED]);
      chk(motorPower, st[2:0]);
      chk(coarseSensorPower, s);
      chk(filterBypass, b);
      bus(ADDR_STATUS, 1'b0, 32'h0, rd);
      chk(rd, {23'h0, s, b, st});
      for (int a = 0; a < AXES; a++) begin
         d = drv(a);
         chk(np[a], (d > 0) ? d : 0);
         chk(nm[a], (d < 0) ? -d : 0);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // watchdog and main sequence
   // ----------------------------------------------------------------
   // about 5.3k clocks expected; a hang is cut well beyond that
   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      end_sim();
   end

   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      req = '0;
      tidalErr = '0;
      coarseLevelIn = 2'b00;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      check_all();
      bus(ADDR_AMP, 1'b0, 32'h0, rd);
      chk(rd, 32'h00604010);
      bus(ADDR_CMD, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus(32'h0000000c, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      // motors on by pin: automatic fine follows the tidal words
      for (int a = 0; a < AXES; a++) cmd_pin(a);
      check_all();
      // new amplitudes, random but inside the seven-bit fields
      wv = rnd() & 32'h007f7f7f;
      bus(ADDR_AMP, 1'b1, wv, rd);
      bus(ADDR_AMP, 1'b0, 32'h0, rd);
      chk(rd, wv);
      ampL = wv[6:0];
      ampH = wv[14:8];
      ampC = wv[22:16];
      // automatic coarse: horizontals by sensor sign, vertical idle
      cmd_pin(CMD_COARSE);
      repeat (2) begin
         coarseLevelIn <= NUM_HORIZ'(rnd());
         check_all();
      end
      // command mode with the coarse bit left set
      cmd_reg(7'h08);
      check_all();
      for (int i = 0; i < 4; i++) begin
         if (i == 0) cmd_pin(CMD_DIR);
         else if (i == 1) cmd_reg(7'h40);
         else if (i == 2) cmd_reg(7'h20);
         else cmd_pin(CMD_SPEED);
         check_all();
      end
      // back to automatic by pin, second coarse pulse restores fine
      cmd_pin(CMD_MODE);
      cmd_pin(CMD_COARSE);
      check_all();
      cmd_reg(7'h12);
      check_all();
      // clock enable low freezes the pulse trains, motor power and filter bypass
      ce <= 1'b0;
      @(posedge core_clk);
      wv = 32'({pulsePlus, pulseMinus, motorPower, filterBypass});
      repeat (40) @(posedge core_clk);
      chk({pulsePlus, pulseMinus, motorPower, filterBypass}, wv);
      ce <= 1'b1;
      // the preset pin is not a state bit, so the model is cleared directly
      i_src.pulse(NUM_CMD);
      st = 7'h00;
      check_all();
      end_sim();
   end
endmodule
